// File: core/aad_acc_alu.sv
// How it works
// RULE1: divide takes accumulator and extension as one dividend over the memory word
// RULE2: divide leaves quotient in accumulator and undivided remainder in extension
// RULE3: quotient is positive when signs match, negative when they differ
// RULE4: exactly 23 quotient magnitude bits; tiny quotients may come out zero
// RULE5: quotient binary point is dividend scale minus divisor scale
// RULE6: remainder keeps the dividend sign, scaled at dividend scale minus 23
// RULE7: remainder shifted right 23 plus divisor times quotient gives the dividend; not met for divisor -1, which reaches the divider as zero
// RULE8: overflow set when true quotient is at least 1 or below -1
// RULE9: program should zero extension before dividing a single-word dividend
// RULE10: code 65 divides and takes 10 cycles
// RULE11: code 77 loads the effective address itself into index, 2 cycles
// RULE12: code 14 ANDs memory into accumulator in 2 cycles
// RULE13: code 16 ORs memory into accumulator in 2 cycles
// RULE14: code 17 XORs memory into accumulator in 2 cycles
// RULE15: code 57 adds with carry, code 56 subtracts with carry, 2 cycles each
// RULE16: change code 00012 moves extension to accumulator, clears extension, 1 cycle
// RULE17: change code 00005 moves accumulator to extension, clears accumulator, 1 cycle
// RULE18: accumulator, extension and index are 24-bit two's complement, bit 0 sign
`timescale 1ns/1ps
module aad_acc_alu (
   // clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rst_b_i,
   // sequencer request
   input  wire aad_pkg::aad_req_s req_i,
   input  wire logic              ovf_clr_i,
   // status
   output logic                   busy_o,
   output logic                   done_o,
   output logic                   ovf_o,
   output logic                   carry_o,
   // registers
   output aad_pkg::aad_word_t     acc_o,
   output aad_pkg::aad_word_t     ext_o,
   output aad_pkg::aad_word_t     idx_o
);
   aad_pkg::aad_word_t acc;
   aad_pkg::aad_word_t ext;
   aad_pkg::aad_word_t idx;
   aad_pkg::aad_word_t m_q;
   logic [5:0]         op_q;
   logic [13:0]        ea_q;
   logic [3:0]         cnt;
   logic               busy;
   logic               done;
   logic               ovf;
   logic               carry;

   // request decode
   logic        req_div;
   logic        req_mem;
   logic        req_rc;
   logic        req_known;
   logic        take;
   logic [3:0]  req_cyc;

   assign req_div = req_i.opcode == aad_pkg::AAD_OP_DIV;
   assign req_mem = (req_i.opcode == aad_pkg::AAD_OP_LOAD_IDX_ADDR) ||
                    (req_i.opcode == aad_pkg::AAD_OP_AND) ||
                    (req_i.opcode == aad_pkg::AAD_OP_OR)  ||
                    (req_i.opcode == aad_pkg::AAD_OP_XOR) ||
                    (req_i.opcode == aad_pkg::AAD_OP_ADC) ||
                    (req_i.opcode == aad_pkg::AAD_OP_SBC);
   assign req_rc  = (req_i.opcode == aad_pkg::AAD_OP_RC) &&
                    ((req_i.addr == aad_pkg::AAD_RC_EXT_TO_ACC) ||
                     (req_i.addr == aad_pkg::AAD_RC_ACC_TO_EXT));
   assign req_known = req_div || req_mem || req_rc;
   // unknown codes and requests while busy are dropped silently
   assign take = req_i.valid && !busy && req_known;
   assign req_cyc = req_div ? aad_pkg::AAD_CYC_DIV :      // RULE10
                    req_rc  ? aad_pkg::AAD_CYC_RC  :      // RULE16
                              aad_pkg::AAD_CYC_MEM;       // RULE12

   // latched operation decode
   logic is_div;
   logic is_load_idx;
   logic is_alu;
   logic is_e2a;
   logic is_a2e;
   logic is_arith;
   logic commit;
   aad_pkg::aad_alu_e alu_kind;

   assign is_div   = op_q == aad_pkg::AAD_OP_DIV;
   assign is_load_idx = op_q == aad_pkg::AAD_OP_LOAD_IDX_ADDR;
   assign is_e2a   = (op_q == aad_pkg::AAD_OP_RC) && (ea_q == aad_pkg::AAD_RC_EXT_TO_ACC);
   assign is_a2e   = (op_q == aad_pkg::AAD_OP_RC) && (ea_q == aad_pkg::AAD_RC_ACC_TO_EXT);
   assign is_arith = (op_q == aad_pkg::AAD_OP_ADC) || (op_q == aad_pkg::AAD_OP_SBC);
   assign is_alu   = is_arith || (op_q == aad_pkg::AAD_OP_AND) ||
                     (op_q == aad_pkg::AAD_OP_OR) || (op_q == aad_pkg::AAD_OP_XOR);
   assign commit   = busy && (cnt == aad_pkg::AAD_CNT_RST);
   assign alu_kind = (op_q == aad_pkg::AAD_OP_AND) ? aad_pkg::AAD_ALU_AND :
                     (op_q == aad_pkg::AAD_OP_OR)  ? aad_pkg::AAD_ALU_OR  :
                     (op_q == aad_pkg::AAD_OP_XOR) ? aad_pkg::AAD_ALU_XOR :
                     (op_q == aad_pkg::AAD_OP_ADC) ? aad_pkg::AAD_ALU_ADC :
                                                     aad_pkg::AAD_ALU_SBC;

   aad_pkg::aad_alu_s alu_res;

   aad_logic_unit u_logic (
      .kind_i  (alu_kind),
      .carry_i (carry),
      .acc_i   (acc),
      .mem_i   (m_q),
      .res_o   (alu_res)
   );

   // divide front end: sign-magnitude split of the double-length dividend;
   // extension sign bit is not part of the value, so stale bits corrupt it
   logic [46:0] dvd;
   logic [46:0] dvd_mag;
   logic [23:0] den_mag;
   logic        n_neg;
   logic        q_neg;
   aad_pkg::aad_word_t div_m;
   logic [22:0] quo_mag;
   logic [22:0] rem_mag;
   logic        div_ovf;
   aad_pkg::aad_word_t quo_s;
   aad_pkg::aad_word_t rem_s;

   // the divisor is the request operand at start, the latched one later
   assign div_m   = take ? req_i.operand : m_q;
   assign dvd     = {acc, ext[1:23]};                              // RULE1 RULE9 RULE18
   assign n_neg   = acc[0];
   assign q_neg   = acc[0] ^ div_m[0];                             // RULE3
   assign dvd_mag = n_neg ? 47'(-dvd) : dvd;
   assign den_mag = div_m[0] ? 24'(-div_m) : div_m;
   // quotient magnitude of 2^23 or more only fits as exactly -1
   assign div_ovf = (dvd_mag[46:23] > den_mag) ||                  // RULE8
                    ((dvd_mag[46:23] == den_mag) && (!q_neg || (dvd_mag[22:0] != 23'h000000)));

   aad_divider u_div (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .start_i    (take && req_div),
      .num_hi_i   (dvd_mag[45:23]),
      .num_lo_i   (dvd_mag[22:0]),
      .den_i      (den_mag[22:0]),
      .quo_o      (quo_mag),
      .rem_o      (rem_mag)
   );

   // fractional quotient keeps scale of dividend minus divisor
   assign quo_s = q_neg ? 24'(-{1'b0, quo_mag}) : {1'b0, quo_mag}; // RULE3 RULE5
   assign rem_s = n_neg ? 24'(-{1'b0, rem_mag}) : {1'b0, rem_mag}; // RULE6 RULE7

   // register write-back
   aad_pkg::aad_word_t next_acc;
   aad_pkg::aad_word_t next_ext;
   aad_pkg::aad_word_t next_idx;
   logic               next_ovf;
   logic               next_carry;
   logic               ovf_set;

   assign next_acc = !commit ? acc           :
                     is_div  ? quo_s         :            // RULE2
                     is_alu  ? alu_res.result :           // RULE12 RULE13 RULE14 RULE15
                     is_e2a  ? ext           :            // RULE16
                     is_a2e  ? aad_pkg::AAD_WORD_RST :    // RULE17
                               acc;
   assign next_ext = !commit ? ext           :
                     is_div  ? rem_s         :            // RULE2
                     is_e2a  ? aad_pkg::AAD_WORD_RST :    // RULE16
                     is_a2e  ? acc           :            // RULE17
                               ext;
   assign next_idx = (commit && is_load_idx) ? {10'h000, ea_q} : idx; // RULE11
   assign next_carry = (commit && is_arith) ? alu_res.carry : carry;
   assign ovf_set  = commit && ((is_div && div_ovf) || (is_arith && alu_res.ovf)); // RULE8
   // a fresh overflow beats a clear in the same cycle
   assign next_ovf = ovf_set || (ovf && !ovf_clr_i);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy <= 1'b0;
         cnt  <= aad_pkg::AAD_CNT_RST;
         op_q <= aad_pkg::AAD_OP_RST;
         ea_q <= aad_pkg::AAD_EA_RST;
         m_q  <= aad_pkg::AAD_WORD_RST;
      end else if (take) begin
         busy <= 1'b1;
         cnt  <= req_cyc - 4'h1;
         op_q <= req_i.opcode;
         ea_q <= req_i.addr;
         m_q  <= req_i.operand;
      end else if (commit) begin
         busy <= 1'b0;
      end else if (busy) begin
         cnt  <= cnt - 4'h1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc   <= aad_pkg::AAD_WORD_RST;
         ext   <= aad_pkg::AAD_WORD_RST;
         idx   <= aad_pkg::AAD_WORD_RST;
         ovf   <= 1'b0;
         carry <= 1'b0;
         done  <= 1'b0;
      end else begin
         acc   <= next_acc;
         ext   <= next_ext;
         idx   <= next_idx;
         ovf   <= next_ovf;
         carry <= next_carry;
         done  <= commit;
      end
   end

   assign busy_o  = busy;
   assign done_o  = done;
   assign ovf_o   = ovf;
   assign carry_o = carry;
   assign acc_o   = acc;
   assign ext_o   = ext;
   assign idx_o   = idx;

   // checking helpers: snapshot of the divide inputs at commit
   logic [46:0]        hlp_dvd;
   aad_pkg::aad_word_t hlp_m;
   logic               hlp_ovf;
   logic               hlp_qneg;
   logic signed [71:0] chk_lhs;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hlp_dvd  <= 47'h000000000000;
         hlp_m    <= aad_pkg::AAD_WORD_RST;
         hlp_ovf  <= 1'b0;
         hlp_qneg <= 1'b0;
      end else if (commit && is_div) begin
         hlp_dvd  <= dvd;
         hlp_m    <= m_q;
         hlp_ovf  <= div_ovf;
         hlp_qneg <= q_neg;
      end
   end

   // integer form: the 23-place scale shift of the remainder cancels out
   assign chk_lhs = (72'(signed'(acc)) * 72'(signed'(hlp_m))) + 72'(signed'(ext)); // RULE7

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_div_cycles;
      take && req_div |-> ##1 (!done)[*5] ##1 (!done)[*5] ##1 done;
   endproperty
   a_div_cycles: assert property (p_div_cycles) else $error("divide not 10 cycles"); // RULE10

   property p_mem_cycles;
      take && req_mem |-> ##1 !done ##1 !done ##1 done;
   endproperty
   a_mem_cycles: assert property (p_mem_cycles) else $error("memory op not 2 cycles"); // RULE12

   property p_rc_cycles;
      take && req_rc |-> ##1 !done ##1 done;
   endproperty
   a_rc_cycles: assert property (p_rc_cycles) else $error("register change not 1 cycle"); // RULE16

   property p_and;
      take && (req_i.opcode == aad_pkg::AAD_OP_AND) |->
         ##3 acc == ($past(acc, 3) & $past(req_i.operand, 3));
   endproperty
   a_and: assert property (p_and) else $error("and result wrong"); // RULE12

   property p_or;
      take && (req_i.opcode == aad_pkg::AAD_OP_OR) |->
         ##3 acc == ($past(acc, 3) | $past(req_i.operand, 3));
   endproperty
   a_or: assert property (p_or) else $error("or result wrong"); // RULE13

   property p_xor;
      take && (req_i.opcode == aad_pkg::AAD_OP_XOR) |->
         ##3 acc == ($past(acc, 3) ^ $past(req_i.operand, 3));
   endproperty
   a_xor: assert property (p_xor) else $error("xor result wrong"); // RULE14

   property p_load_idx;
      take && (req_i.opcode == aad_pkg::AAD_OP_LOAD_IDX_ADDR) |->
         ##3 idx == {10'h000, $past(req_i.addr, 3)};
   endproperty
   a_load_idx: assert property (p_load_idx) else $error("index not loaded with address"); // RULE11

   property p_e2a;
      take && req_rc && (req_i.addr == aad_pkg::AAD_RC_EXT_TO_ACC) |->
         ##2 (acc == $past(ext, 2)) && (ext == aad_pkg::AAD_WORD_RST);
   endproperty
   a_e2a: assert property (p_e2a) else $error("extension to accumulator wrong"); // RULE16

   property p_a2e;
      take && req_rc && (req_i.addr == aad_pkg::AAD_RC_ACC_TO_EXT) |->
         ##2 (ext == $past(acc, 2)) && (acc == aad_pkg::AAD_WORD_RST);
   endproperty
   a_a2e: assert property (p_a2e) else $error("accumulator to extension wrong"); // RULE17

   property p_div_ovf;
      commit && is_div && div_ovf |=> ovf;
   endproperty
   a_div_ovf: assert property (p_div_ovf) else $error("divide overflow missed"); // RULE8

   property p_div_rebuild;
      done && is_div && !hlp_ovf && (hlp_m != 24'h800000) |->
         chk_lhs == 72'(signed'(hlp_dvd));
   endproperty
   a_div_rebuild: assert property (p_div_rebuild) else $error("remainder does not rebuild"); // RULE7

   property p_quo_sign;
      done && is_div && !hlp_ovf && (acc != aad_pkg::AAD_WORD_RST) |-> acc[0] == hlp_qneg;
   endproperty
   a_quo_sign: assert property (p_quo_sign) else $error("quotient sign wrong"); // RULE3

   property p_rem_sign;
      done && is_div && !hlp_ovf && (ext != aad_pkg::AAD_WORD_RST) |-> ext[0] == hlp_dvd[46];
   endproperty
   a_rem_sign: assert property (p_rem_sign) else $error("remainder sign wrong"); // RULE6

   property p_busy_hold;
      busy && !commit |=> $stable(acc) && $stable(ext) && $stable(idx);
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("registers moved mid operation");

   property p_adc_sum;
      take && (req_i.opcode == aad_pkg::AAD_OP_ADC) |->
         ##3 {carry, acc} == ({1'b0, $past(acc, 3)} + {1'b0, $past(req_i.operand, 3)}
                              + {24'h000000, $past(carry, 3)});
   endproperty
   a_adc_sum: assert property (p_adc_sum) else $error("add with carry wrong"); // RULE15

   property p_sbc_dif;
      take && (req_i.opcode == aad_pkg::AAD_OP_SBC) |->
         ##3 {carry, acc} == ({1'b0, $past(acc, 3)} - {1'b0, $past(req_i.operand, 3)}
                              - {24'h000000, $past(carry, 3)});
   endproperty
   a_sbc_dif: assert property (p_sbc_dif) else $error("subtract with carry wrong"); // RULE15

   property p_ovf_sticky;
      ovf && !ovf_clr_i |=> ovf;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost without clear"); // RULE8

   property p_done_pulse;
      done |=> !done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

   c_div_ok:   cover property (done && is_div && !hlp_ovf && (ext != aad_pkg::AAD_WORD_RST));
   c_div_ovf:  cover property (commit && is_div && div_ovf);
   c_adc_cy:   cover property (commit && is_arith && alu_res.carry);
   c_back2back: cover property (done ##3 done);
endmodule : aad_acc_alu

// File: core/aad_pkg.sv
package aad_pkg;

   // bit 0 is the sign, so words are declared big-end first
   typedef logic [0:23] aad_word_t;

   localparam int unsigned AAD_MAG_W = 23;

   // operation codes (octal 65, 77, 14, 16, 17, 57, 56, 46)
   localparam logic [5:0] AAD_OP_DIV  = 6'h35;
   localparam logic [5:0] AAD_OP_LOAD_IDX_ADDR = 6'h3F;
   localparam logic [5:0] AAD_OP_AND  = 6'h0C;
   localparam logic [5:0] AAD_OP_OR   = 6'h0E;
   localparam logic [5:0] AAD_OP_XOR  = 6'h0F;
   localparam logic [5:0] AAD_OP_ADC  = 6'h2F;
   localparam logic [5:0] AAD_OP_SBC  = 6'h2E;
   localparam logic [5:0] AAD_OP_RC   = 6'h26;

   // register-change address fields (octal 00012 and 00005)
   localparam logic [13:0] AAD_RC_EXT_TO_ACC = 14'h000A;
   localparam logic [13:0] AAD_RC_ACC_TO_EXT = 14'h0005;

   // execution times in cycles
   localparam logic [3:0] AAD_CYC_DIV = 4'hA;
   localparam logic [3:0] AAD_CYC_MEM = 4'h2;
   localparam logic [3:0] AAD_CYC_RC  = 4'h1;

   // divider stepping
   localparam logic [4:0] AAD_QBITS      = 5'h17;
   localparam logic [4:0] AAD_DIV_IDLE   = 5'h18;
   localparam int unsigned AAD_STEPS_CYC = 3;

   // values after reset
   localparam aad_word_t  AAD_WORD_RST = 24'h000000;
   localparam logic [3:0] AAD_CNT_RST  = 4'h0;
   localparam logic [5:0] AAD_OP_RST   = 6'h00;
   localparam logic [13:0] AAD_EA_RST  = 14'h0000;

   typedef struct packed {
      logic       valid;
      logic [5:0] opcode;
      logic [13:0] addr;
      aad_word_t  operand;
   } aad_req_s;

   typedef enum logic [2:0] {
      AAD_ALU_AND = 3'b000,
      AAD_ALU_OR  = 3'b001,
      AAD_ALU_XOR = 3'b010,
      AAD_ALU_ADC = 3'b011,
      AAD_ALU_SBC = 3'b100
   } aad_alu_e;

   typedef struct packed {
      aad_word_t result;
      logic      carry;
      logic      ovf;
   } aad_alu_s;

endpackage : aad_pkg

// File: core/aad_logic_unit.sv
`timescale 1ns/1ps
module aad_logic_unit (
   // operation select
   input  wire aad_pkg::aad_alu_e kind_i,
   input  wire logic              carry_i,
   // operands
   input  wire aad_pkg::aad_word_t acc_i,
   input  wire aad_pkg::aad_word_t mem_i,
   // result
   output aad_pkg::aad_alu_s       res_o
);
   logic [24:0] sum;
   logic [24:0] dif;
   logic        sum_ovf;
   logic        dif_ovf;

   assign sum = {1'b0, acc_i} + {1'b0, mem_i} + {24'h000000, carry_i}; // RULE15
   assign dif = {1'b0, acc_i} - {1'b0, mem_i} - {24'h000000, carry_i}; // RULE15
   assign sum_ovf = (acc_i[0] == mem_i[0]) && (sum[23] != acc_i[0]);
   assign dif_ovf = (acc_i[0] != mem_i[0]) && (dif[23] != acc_i[0]);

   always_comb begin
      res_o = '0;
      case (kind_i)
         aad_pkg::AAD_ALU_AND: res_o.result = acc_i & mem_i; // RULE12
         aad_pkg::AAD_ALU_OR:  res_o.result = acc_i | mem_i; // RULE13
         aad_pkg::AAD_ALU_XOR: res_o.result = acc_i ^ mem_i; // RULE14
         aad_pkg::AAD_ALU_ADC: begin
            res_o.result = sum[23:0];
            res_o.carry  = sum[24];
            res_o.ovf    = sum_ovf;
         end
         aad_pkg::AAD_ALU_SBC: begin
            res_o.result = dif[23:0];
            res_o.carry  = dif[24];
            res_o.ovf    = dif_ovf;
         end
         default: res_o = '0;
      endcase
   end
endmodule : aad_logic_unit

// File: core/aad_divider.sv
`timescale 1ns/1ps
module aad_divider (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   // start with magnitudes
   input  wire logic        start_i,
   input  wire logic [22:0] num_hi_i,
   input  wire logic [22:0] num_lo_i,
   input  wire logic [22:0] den_i,
   // magnitude results
   output logic [22:0]      quo_o,
   output logic [22:0]      rem_o
);
   logic [22:0] part;
   logic [22:0] low;
   logic [22:0] quo;
   logic [4:0]  steps;
   logic [22:0] p_chain [0:3];
   logic [22:0] l_chain [0:3];
   logic [22:0] q_chain [0:3];
   logic [4:0]  next_steps;

   assign p_chain[0] = part;
   assign l_chain[0] = low;
   assign q_chain[0] = quo;

   // restoring steps, three per cycle; partial stays below the divisor when it starts below it
   for (genvar i = 0; i < aad_pkg::AAD_STEPS_CYC; i++) begin : g_step
      logic        act;
      logic [23:0] trial;
      logic [23:0] diff;
      logic        ge;
      assign act   = (steps + 5'(i)) < aad_pkg::AAD_QBITS; // RULE4
      assign trial = {p_chain[i], l_chain[i][22]};
      assign diff  = trial - {1'b0, den_i};
      assign ge    = trial >= {1'b0, den_i};
      assign p_chain[i+1] = !act ? p_chain[i] : (ge ? diff[22:0] : trial[22:0]);
      assign l_chain[i+1] = !act ? l_chain[i] : {l_chain[i][21:0], 1'b0};
      assign q_chain[i+1] = !act ? q_chain[i] : {q_chain[i][21:0], ge};
   end

   assign next_steps = (steps >= aad_pkg::AAD_QBITS) ? steps : steps + 5'h03;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         part  <= 23'h000000;
         low   <= 23'h000000;
         quo   <= 23'h000000;
         steps <= aad_pkg::AAD_DIV_IDLE;
      end else if (start_i) begin
         part  <= num_hi_i;
         low   <= num_lo_i;
         quo   <= 23'h000000;
         steps <= 5'h00;
      end else begin
         part  <= p_chain[3];
         low   <= l_chain[3];
         quo   <= q_chain[3];
         steps <= next_steps;
      end
   end

   assign quo_o = quo;
   assign rem_o = part; // RULE6

   property p_div_steps;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      start_i |=> (steps == 5'h00) ##8 (steps == aad_pkg::AAD_DIV_IDLE);
   endproperty
   a_div_steps: assert property (p_div_steps) else $error("divider step count wrong"); // RULE4
endmodule : aad_divider

// File: tb/aad_seq_model.sv
`timescale 1ns/1ps
module aad_seq_model (
   // clock
   input  wire logic          core_clk_i,
   // block status
   input  wire logic          busy_i,
   input  wire logic          done_i,
   // request
   output aad_pkg::aad_req_s  req_o
);
   initial req_o = '0;

   // one request at a time; completion bounded so a hang returns ok low
   task automatic issue(input logic [5:0] opc, input logic [13:0] addr,
                        input aad_pkg::aad_word_t m, output logic ok);
      int n;
      ok = 1'b0;
      @(posedge core_clk_i);
      req_o <= '{valid: 1'b1, opcode: opc, addr: addr, operand: m};
      // busy is low here, so the next edge takes it
      @(posedge core_clk_i);
      // released fields flip so stale values cannot pass
      req_o <= '{valid: 1'b0, opcode: ~opc, addr: ~addr, operand: ~m};
      for (n = 0; n < 16 && !ok; n++) begin
         @(negedge core_clk_i);
         if (done_i === 1'b1 && busy_i === 1'b0) ok = 1'b1;
      end
   endtask : issue
endmodule : aad_seq_model

// File: tb/aad_acc_alu_tb.sv
`timescale 1ns/1ps
module aad_acc_alu_tb;
   typedef struct {
      aad_pkg::aad_word_t acc, ext, idx;
      logic               car, ovf, regs;
      int                 cyc;
   } aad_exp_s;

   logic               core_clk_i = 1'b0;
   logic               rst_b_i    = 1'b0;
   logic               ovf_clr_i  = 1'b0;
   aad_pkg::aad_req_s  req;
   logic               busy, done, ovf, car, ok;
   aad_pkg::aad_word_t acc, ext, idx, m_acc, m_ext, m_idx, hi, mg;
   logic               m_car, m_ovf, m_unk;
   aad_exp_s           exp_q[$];
   int                 errors = 0, num_checks = 0, cyc_cnt = 0, i;
   logic [31:0]        seed = 32'hB86AD7C3;

   always #25 core_clk_i = ~core_clk_i;

   aad_acc_alu dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_i(req),
      .ovf_clr_i(ovf_clr_i), .busy_o(busy), .done_o(done), .ovf_o(ovf),
      .carry_o(car), .acc_o(acc), .ext_o(ext), .idx_o(idx));
   aad_seq_model seq_u (.core_clk_i(core_clk_i), .busy_i(busy), .done_i(done), .req_o(req));

   function automatic logic [23:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
      return seed[23:0];
   endfunction : rnd

   task check(string what, logic [31:0] seen, logic [31:0] expv);
      num_checks++;
      if (seen !== expv) begin
         errors++;
         $display("FAIL t=%0t %s seen %h expected %h", $time, what, seen, expv);
      end
   endtask : check

   task final_report;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report

   // reference model: note the expectation, then hand the request over
   task op(logic [5:0] opc, logic [13:0] addr, aad_pkg::aad_word_t m);
      aad_exp_s    e;
      logic [24:0] s;
      longint      d, q, r, sv;
      e.cyc  = 2;
      // registers left undefined by an overflowing divide are not compared once
      e.regs = !m_unk;
      m_unk  = 1'b0;
      sv = longint'($signed(m_acc)) - longint'($signed(m)) - longint'(m_car);
      case (opc)
         aad_pkg::AAD_OP_AND: m_acc = m_acc & m;
         aad_pkg::AAD_OP_OR:  m_acc = m_acc | m;
         aad_pkg::AAD_OP_XOR: m_acc = m_acc ^ m;
         aad_pkg::AAD_OP_LOAD_IDX_ADDR: m_idx = {10'h000, addr};
         aad_pkg::AAD_OP_ADC, aad_pkg::AAD_OP_SBC: begin
            if (opc == aad_pkg::AAD_OP_ADC) begin
               s  = {1'b0, m_acc} + {1'b0, m} + {24'h000000, m_car};
               sv = longint'($signed(m_acc)) + longint'($signed(m)) + longint'(m_car);
            end else s = {1'b0, m_acc} - {1'b0, m} - {24'h000000, m_car};
            m_acc = s[23:0];
            m_car = s[24];
            if (sv > 8388607 || sv < -8388608) m_ovf = 1'b1;
         end
         aad_pkg::AAD_OP_RC: begin
            e.cyc = 1;
            if (addr == aad_pkg::AAD_RC_EXT_TO_ACC) begin
               m_acc = m_ext;
               m_ext = 24'h000000;
            end else begin
               m_ext = m_acc;
               m_acc = 24'h000000;
            end
         end
         default: begin
            e.cyc = 10;
            d = longint'($signed({m_acc, m_ext[1:23]}));
            q = d / longint'($signed(m));
            r = d % longint'($signed(m));
            // exact -1 needs 24 magnitude bits: 23 come out, the divisor stays behind
            if (q == -8388608 && r == 0) begin
               q = -8388607;
               r = d - q * longint'($signed(m));
            end
            if (q >= 8388608 || q < -8388608 || (q == -8388608 && r != 0)) begin
               m_ovf  = 1'b1;
               e.regs = 1'b0;
               m_unk  = 1'b1;
            end else begin
               m_acc = q[23:0];
               m_ext = r[23:0];
            end
         end
      endcase
      e.acc = m_acc;
      e.ext = m_ext;
      e.idx = m_idx;
      e.car = m_car;
      e.ovf = m_ovf;
      exp_q.push_back(e);
      seq_u.issue(opc, addr, m, ok);
      if (!ok) begin
         check("no completion", 32'h0, 32'h1);
         final_report();
      end
   endtask : op

   // builds the dividend word by word; lo of zero clears extension first
   task divide(aad_pkg::aad_word_t h, aad_pkg::aad_word_t lo, aad_pkg::aad_word_t m);
      op(aad_pkg::AAD_OP_AND, 14'h0000, 24'h000000);
      op(aad_pkg::AAD_OP_OR, 14'h0000, lo);
      op(aad_pkg::AAD_OP_RC, aad_pkg::AAD_RC_ACC_TO_EXT, 24'h000000);
      op(aad_pkg::AAD_OP_OR, 14'h0000, h);
      op(aad_pkg::AAD_OP_DIV, 14'(rnd()), m);
      if (m_ovf) begin
         @(posedge core_clk_i) ovf_clr_i <= 1'b1;
         @(posedge core_clk_i) ovf_clr_i <= 1'b0;
         m_ovf = 1'b0;
         // results after overflow are undefined, so resynchronise
         op(aad_pkg::AAD_OP_AND, 14'h0000, 24'h000000);
         op(aad_pkg::AAD_OP_RC, aad_pkg::AAD_RC_ACC_TO_EXT, 24'h000000);
      end
   endtask : divide

   always @(negedge core_clk_i) begin : mon
      aad_exp_s me;
      if (busy === 1'b1) cyc_cnt++;
      else if (done === 1'b1) begin
         if (exp_q.size() == 0) check("spare done", 32'h1, 32'h0);
         else begin
            me = exp_q.pop_front();
            check("cycles", cyc_cnt, me.cyc);
            if (me.regs) begin
               check("acc", acc, me.acc);
               check("ext", ext, me.ext);
            end
            check("idx", idx, me.idx);
            check("ovf", ovf, me.ovf);
            check("carry", car, me.car);
         end
         cyc_cnt = 0;
      end
   end

   initial begin
      {m_acc, m_ext, m_idx, m_car, m_ovf, m_unk} = '0;
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      @(negedge core_clk_i);
      check("reset", {acc, ovf, car}, 32'h0);
      for (i = 0; i < 9; i++)
         op(i % 3 == 0 ? aad_pkg::AAD_OP_AND : i % 3 == 1 ? aad_pkg::AAD_OP_OR
            : aad_pkg::AAD_OP_XOR, 14'(rnd()), rnd());
      $display("test logic done");
      for (i = 0; i < 3; i++) op(aad_pkg::AAD_OP_LOAD_IDX_ADDR, 14'(rnd()), rnd());
      $display("test index done");
      for (i = 0; i < 10; i++)
         op(i[0] ? aad_pkg::AAD_OP_SBC : aad_pkg::AAD_OP_ADC, 14'(rnd()), rnd());
      $display("test add subtract done");
      op(aad_pkg::AAD_OP_RC, aad_pkg::AAD_RC_ACC_TO_EXT, rnd());
      op(aad_pkg::AAD_OP_OR, 14'h0000, rnd());
      op(aad_pkg::AAD_OP_RC, aad_pkg::AAD_RC_EXT_TO_ACC, rnd());
      $display("test change done");
      for (i = 0; i < 12; i++) begin
         mg = (rnd() & 24'h3FFFFF) | 24'h400000;
         hi = (i % 4 == 0) ? 24'h000000 : (rnd() & 24'h1FFFFF);
         divide(i[1] ? -hi : hi, rnd(), i[2] ? -mg : mg);
      end
      divide(-24'h400000, 24'h000000, 24'h400000);
      divide(24'hFFFFFF, 24'h7FFFFB, 24'h400000);
      divide(24'h000000, 24'h000005, 24'h400000);
      divide(24'h100000, 24'h000000, 24'h000100);
      $display("test divide done");
      @(posedge core_clk_i) rst_b_i <= 1'b0;
      @(negedge core_clk_i);
      check("reset again", {|acc, |ext, |idx, ovf, car}, 32'h0);
      $display("test reset done");
      final_report();
   end
endmodule : aad_acc_alu_tb
